// file: uhrs_ctrl.sv
`include "uhrs_regs.svh"
`default_nettype none

// Function
// R01: normal stop finishes command, resets frame counter
// R02: normal run restarts at frame start
// R03: debug stop freezes frame counter, keeps status
// R04: debug run clears run per fetch, steps
// R05: frame index writable only while run clear
// R06: status bits cleared by writing one
// R07: halted flag set once really stopped
// R08: consistency failure sets bit 4, stops, errors
// R09: bus abort sets bit 3, stops, errors
// R10: resume sets bit 2 only in suspend
// R11: transaction error sets bit 1, maybe 0
// R12: completion with interrupt flag sets bit 0
// R13: enabled short packet also sets bit 0
// R14: enabled active source raises host interrupt
// R15: process error always raises host interrupt
// R16: disabled sources still set status flags
// R17: enable bits short, complete, resume, error
// R18: software changes debug bit only when halted
// R19: global suspend stops transactions, resume detected
// R20: flags stay set; zero writes ignored
module uhrs_ctrl
  import uhrs_pkg::*;
#(
  parameter int FRAME_CYCLES = `UHRS_FRAME_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // i/o register port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // command register bits
  input wire logic cmd_run,
  input wire logic single_step_debug_bit,
  input wire logic global_suspend_bit,
  output logic run_clr,
  // schedule engine events
  input wire logic eng_busy,
  input wire logic td_fetch,
  input wire logic td_done,
  input wire logic td_ioc,
  input wire logic td_err,
  input wire logic td_short,
  input wire logic td_spd,
  input wire logic resume_det,
  input wire logic check_fail,
  input wire logic bus_abort,
  // schedule and frame control
  output logic exec_en,
  output logic sof_start,
  output logic frame_tick,
  output logic frame_index_wr_ok,
  // system side
  output logic host_irq,
  output logic sys_err
);

  uhrs_regs_t s_r;
  uhrs_regs_t s_nxt;

  localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);

  // byte-enable mask for a 16-bit write
  function automatic logic [15:0] be_mask(input logic [1:0] be);
    be_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // true when the access hits the given register offset
  function automatic logic addr_is(input logic [7:0] a,
    input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // sticky flag update, a set in the clearing cycle wins
  function automatic logic [5:0] sts_update(input logic [5:0] cur,
    input logic [5:0] clr, input logic [5:0] set);
    sts_update = (cur & ~clr) | set;
  endfunction

  // host interrupt from flags, completion causes and enables
  function automatic logic irq_calc(input logic [5:0] sts,
    input logic interrupt_on_complete_flag, input logic shrt, input logic [3:0] en);
    logic txerr_irq;
    logic resume_irq;
    logic ioc_irq;
    logic short_irq;
    logic fatal_any;
    txerr_irq = sts[`UHRS_STS_TXERR] && en[`UHRS_EN_TXERR]; // see R14
    resume_irq = sts[`UHRS_STS_RESUME] && en[`UHRS_EN_RESUME];
    ioc_irq = interrupt_on_complete_flag && en[`UHRS_EN_DONE];
    short_irq = shrt && en[`UHRS_EN_SHORT];
    // fatal errors ignore the enables
    fatal_any = sts[`UHRS_STS_PROCERR] || sts[`UHRS_STS_BUSERR]; // see R15
    irq_calc = txerr_irq || resume_irq || ioc_irq || short_irq
      || fatal_any;
  endfunction

  // read word of a register, reserved bits as zero
  function automatic logic [15:0] read_word(input logic [7:0] a,
    input logic [5:0] sts, input logic [3:0] en);
    read_word = 16'h0000;
    if (addr_is(a, `UHRS_STS_OFS)) begin
      read_word = {10'h000, sts}; // see R16
    end
    if (addr_is(a, `UHRS_INTEN_OFS)) begin
      read_word = {12'h000, en};
    end
  endfunction

  // outputs straight from state
  assign io_rdata = s_r.rdata;
  assign run_clr = s_r.run_clr;
  assign sof_start = s_r.sof_start;
  assign frame_tick = s_r.frame_tick;
  assign sys_err = s_r.sys_err;
  assign host_irq = s_r.irq;
  // no new transactions while draining, stopped or suspended
  assign exec_en = (s_r.st == UHRS_RUNNING) && !global_suspend_bit; // see R19
  assign frame_index_wr_ok = !cmd_run; // see R05

  // next-state logic
  always_comb begin
    logic [15:0] wmask;
    logic [5:0] set_v;
    logic [5:0] clr_v;
    logic done_ioc;
    logic done_short;
    logic fatal;
    logic go;
    logic wr_sts;
    logic wr_en;
    wmask = 16'h0000;
    set_v = 6'h00;
    clr_v = 6'h00;
    done_ioc = 1'b0;
    done_short = 1'b0;
    fatal = 1'b0;
    go = 1'b0;
    wr_sts = 1'b0;
    wr_en = 1'b0;
    s_nxt = s_r;
    s_nxt.sof_start = 1'b0;
    s_nxt.frame_tick = 1'b0;
    s_nxt.run_clr = 1'b0;
    s_nxt.sys_err = 1'b0;

    // register write decode
    wmask = io_wdata & be_mask(io_be);
    wr_sts = io_wr && addr_is(io_addr, `UHRS_STS_OFS);
    wr_en = io_wr && addr_is(io_addr, `UHRS_INTEN_OFS);
    if (wr_sts) begin
      clr_v = wmask[5:0]; // see R06
    end
    if (wr_en) begin
      if (io_be[0]) begin
        s_nxt.en = io_wdata[3:0]; // see R17
      end
    end

    // event sources, set whatever the enables say
    done_ioc = td_done && td_ioc; // see R12
    done_short = td_done && td_spd && td_short; // see R13
    fatal = check_fail || bus_abort;
    if (check_fail) begin
      set_v[`UHRS_STS_PROCERR] = 1'b1; // see R08
    end
    if (bus_abort) begin
      set_v[`UHRS_STS_BUSERR] = 1'b1; // see R09
    end
    if (resume_det && global_suspend_bit) begin
      set_v[`UHRS_STS_RESUME] = 1'b1; // see R10
    end
    if (td_done && td_err) begin
      set_v[`UHRS_STS_TXERR] = 1'b1; // see R11
    end
    if (done_ioc || done_short) begin
      set_v[`UHRS_STS_DONE] = 1'b1; // see R11
    end
    if (fatal) begin
      s_nxt.run_clr = 1'b1; // see R08
      s_nxt.stop_req = 1'b1; // see R09
      s_nxt.sys_err = 1'b1;
    end

    // run control state machine
    go = cmd_run && !s_r.stop_req && !global_suspend_bit;
    case (s_r.st)
      UHRS_STOPPED: begin
        s_nxt.stop_req = s_r.stop_req && cmd_run && !fatal ? 1'b1 : fatal;
        if (!single_step_debug_bit) begin
          s_nxt.fcnt = 16'h0000; // see R01
        end
        if (go && !fatal) begin
          s_nxt.st = UHRS_RUNNING;
          // normal mode restarts on a frame boundary
          s_nxt.sof_start = !single_step_debug_bit; // see R02
        end
      end
      UHRS_RUNNING: begin
        // single step: give the run bit back at each fetch
        if (single_step_debug_bit && td_fetch) begin
          s_nxt.run_clr = 1'b1; // see R04
          s_nxt.stop_req = 1'b1; // see R04
        end
        if (!cmd_run || s_nxt.stop_req || global_suspend_bit) begin
          s_nxt.st = UHRS_DRAINING; // see R01
        end
      end
      UHRS_DRAINING: begin
        // let the command in progress finish
        if (!eng_busy) begin
          s_nxt.st = UHRS_STOPPED;
          s_nxt.stop_req = (s_r.stop_req && cmd_run) || fatal; // see R04
          set_v[`UHRS_STS_HALTED] = 1'b1; // see R07
          if (!single_step_debug_bit) begin
            s_nxt.fcnt = 16'h0000; // see R01
          end
        end
      end
      default: begin
        s_nxt.st = UHRS_STOPPED;
      end
    endcase

    // frame timer runs only while schedule is active
    if (s_r.st != UHRS_STOPPED && s_nxt.st != UHRS_STOPPED) begin
      if (s_r.fcnt >= FRAME_LAST) begin
        s_nxt.fcnt = 16'h0000;
        s_nxt.frame_tick = 1'b1;
      end else begin
        s_nxt.fcnt = s_r.fcnt + 16'h0001;
      end
    end
    // debug stop leaves the frame counter frozen
    if (s_r.st == UHRS_STOPPED && single_step_debug_bit) begin
      s_nxt.fcnt = s_r.fcnt; // see R03
    end

    // sticky flags, a set in the clearing cycle wins
    s_nxt.sts = sts_update(s_r.sts, clr_v, set_v); // see R20
    if (clr_v[`UHRS_STS_DONE]) begin
      s_nxt.ioc_src = 1'b0;
      s_nxt.short_src = 1'b0;
    end
    if (done_ioc) begin
      s_nxt.ioc_src = 1'b1;
    end
    if (done_short) begin
      s_nxt.short_src = 1'b1;
    end

    // interrupt from flags gated by enables
    s_nxt.irq = irq_calc(s_nxt.sts, s_nxt.ioc_src, s_nxt.short_src,
      s_nxt.en); // see R14

    // read data, reserved bits as zero
    if (io_rd) begin
      s_nxt.rdata = read_word(io_addr, s_r.sts, s_r.en); // see R16
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r.st <= UHRS_STOPPED;
      s_r.sts <= `UHRS_STS_RST;
      s_r.ioc_src <= 1'b0;
      s_r.short_src <= 1'b0;
      s_r.en <= `UHRS_EN_RST;
      s_r.stop_req <= 1'b0;
      s_r.fcnt <= 16'h0000;
      s_r.frame_tick <= 1'b0;
      s_r.sof_start <= 1'b0;
      s_r.run_clr <= 1'b0;
      s_r.sys_err <= 1'b0;
      s_r.irq <= 1'b0;
      s_r.rdata <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// file: uhrs_regs.svh
`ifndef UHRS_REGS_SVH
`define UHRS_REGS_SVH

// register offsets in the i/o window
`define UHRS_STS_OFS 8'h02
`define UHRS_INTEN_OFS 8'h04

// status register field positions
`define UHRS_STS_DONE 0
`define UHRS_STS_TXERR 1
`define UHRS_STS_RESUME 2
`define UHRS_STS_BUSERR 3
`define UHRS_STS_PROCERR 4
`define UHRS_STS_HALTED 5
`define UHRS_STS_W 6

// interrupt enable field positions
`define UHRS_EN_TXERR 0
`define UHRS_EN_RESUME 1
`define UHRS_EN_DONE 2
`define UHRS_EN_SHORT 3
`define UHRS_EN_W 4

// reset values
`define UHRS_STS_RST 6'h00
`define UHRS_EN_RST 4'h0

// frame timing
`define UHRS_FRAME_TIME_US 1000
`define UHRS_CLK_KHZ 20000
`define UHRS_FRAME_CYCLES ((`UHRS_FRAME_TIME_US * `UHRS_CLK_KHZ) / 1000)

`endif

// file: uhrs_pkg.sv
`default_nettype none
package uhrs_pkg;

  // run control states, one-hot
  typedef enum logic [2:0] {
    UHRS_STOPPED = 3'b001,
    UHRS_RUNNING = 3'b010,
    UHRS_DRAINING = 3'b100
  } uhrs_state_t;

  // whole state of the block
  typedef struct packed {
    uhrs_state_t st;
    logic [5:0] sts;
    logic ioc_src;
    logic short_src;
    logic [3:0] en;
    logic stop_req;
    logic [15:0] fcnt;
    logic frame_tick;
    logic sof_start;
    logic run_clr;
    logic sys_err;
    logic irq;
    logic [15:0] rdata;
  } uhrs_regs_t;

endpackage
`default_nettype wire

// file: uhrs_ctrl_asserts.sv
`default_nettype none
module uhrs_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command bits and events
  input wire logic cmd_run,
  input wire logic single_step_debug_bit,
  input wire logic global_suspend_bit,
  input wire logic eng_busy,
  input wire logic td_fetch,
  input wire logic check_fail,
  input wire logic bus_abort,
  // outputs watched
  input wire logic run_clr,
  input wire logic exec_en,
  input wire logic sof_start,
  input wire logic frame_tick,
  input wire logic frame_index_wr_ok,
  input wire logic host_irq,
  input wire logic sys_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // fatal cause and its answer
  sequence fatal_s;
    check_fail || bus_abort;
  endsequence
  sequence answer_s;
    sys_err && host_irq;
  endsequence
  // one descriptor fetched in single step
  sequence step_s;
    exec_en && single_step_debug_bit && td_fetch;
  endsequence
  fatal_irq_a: assert property (fatal_s |=> answer_s)
    else $error("fatal error not reported");
  err_cause_a: assert property (sys_err |->
    $past(check_fail) || $past(bus_abort))
    else $error("system error without cause");
  step_stop_a: assert property (step_s |=> run_clr && !exec_en)
    else $error("single step did not stop");
  run_start_a: assert property ($rose(cmd_run) && !exec_en &&
    !eng_busy && !$past(eng_busy) && !$past(exec_en) &&
    !global_suspend_bit && !single_step_debug_bit |=> exec_en && sof_start)
    else $error("run did not start at frame");
  run_stop_a: assert property (!cmd_run |=> !exec_en)
    else $error("running with run bit clear");
  suspend_a: assert property (global_suspend_bit |=> !exec_en)
    else $error("transactions in suspend");
  index_wr_a: assert property (frame_index_wr_ok == !cmd_run)
    else $error("frame index permission wrong");
  tick_gap_a: assert property (frame_tick |=> !frame_tick [*8])
    else $error("frame ticks too close");
endmodule

bind uhrs_ctrl uhrs_ctrl_asserts u_uhrs_ctrl_asserts (.clk, .rst,
  .cmd_run, .single_step_debug_bit, .global_suspend_bit, .eng_busy,
  .td_fetch, .check_fail, .bus_abort, .run_clr, .exec_en, .sof_start,
  .frame_tick, .frame_index_wr_ok, .host_irq, .sys_err);
`default_nettype wire

// file: tb_uhrs_ctrl.sv
`include "uhrs_regs.svh"
`default_nettype none
module tb_uhrs_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, io_wr, io_rd, cmd_run, single_step_debug_bit;
  logic global_suspend_bit, eng_busy, td_fetch, td_done, td_ioc;
  logic td_err, td_short, td_spd, resume_det, check_fail, bus_abort;
  logic [7:0] io_addr;
  logic [1:0] io_be;
  logic [15:0] io_wdata, io_rdata, rd_v;
  logic run_clr, exec_en, sof_start, frame_tick, frame_index_wr_ok;
  logic host_irq, sys_err;
  int n_errors, tests_run;
  uhrs_ctrl #(.FRAME_CYCLES(16)) u_uhrs_ctrl (.clk, .rst, .io_addr,
    .io_wr, .io_rd, .io_be, .io_wdata, .io_rdata, .cmd_run,
    .single_step_debug_bit, .global_suspend_bit, .run_clr, .eng_busy,
    .td_fetch, .td_done, .td_ioc, .td_err, .td_short, .td_spd,
    .resume_det, .check_fail, .bus_abort, .exec_en, .sof_start,
    .frame_tick, .frame_index_wr_ok, .host_irq, .sys_err);
  // clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // step to just after a rising edge
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    cyc();
    io_wr = 0;
    cyc();
  endtask
  task automatic rd(logic [7:0] a);
    io_addr = a;
    io_rd = 1;
    cyc();
    io_rd = 0;
    rd_v = io_rdata;
    cyc();
  endtask
  // one-cycle event pulse
  task automatic ev(logic [7:0] v);
    {td_done, td_ioc, td_err, td_short, td_spd, resume_det, check_fail,
      bus_abort} = v;
    cyc();
    {td_done, td_ioc, td_err, td_short, td_spd, resume_det, check_fail,
      bus_abort} = 8'h00;
  endtask
  task automatic t_regs();
    rd(8'h02);
    chk("status reset", 16'h0000, rd_v);
    wr(8'h04, 16'hFFFF);
    rd(8'h04);
    chk("enable bits", 16'h000F, rd_v);
    io_be = 2'h2;
    wr(8'h04, 16'h0000);
    io_be = 2'h3;
    rd(8'h04);
    chk("enable high byte", 16'h000F, rd_v);
    chk("index wr ok", 16'h0001, 16'(frame_index_wr_ok));
    rd(8'h10);
    chk("unmapped", 16'h0000, rd_v);
  endtask
  task automatic t_flags();
    logic [7:0] v[4] = '{8'hA0, 8'h04, 8'hC0, 8'h98};
    int b[4] = '{1, 2, 0, 0};
    for (int k = 0; k < 4; k++) begin
      global_suspend_bit = (k == 1);
      wr(8'h04, 16'h0000);
      ev(v[k]);
      chk("irq masked", 16'h0000, 16'(host_irq));
      wr(8'h02, 16'h0000);
      rd(8'h02);
      chk("flag", 16'(1 << b[k]), rd_v);
      wr(8'h02, 16'(1 << b[k]));
      rd(8'h02);
      chk("flag clear", 16'h0000, rd_v);
      wr(8'h04, 16'(1 << k));
      ev(v[k]);
      chk("irq on", 16'h0001, 16'(host_irq));
      wr(8'h02, 16'h003F);
    end
    global_suspend_bit = 0;
    wr(8'h04, 16'h0000);
    ev(8'h04);
    cyc();
    ev(8'hE0);
    rd(8'h02);
    chk("error and ioc", 16'h0003, rd_v);
    wr(8'h02, 16'h003F);
  endtask
  task automatic t_fatal();
    ev(8'h02);
    chk("process irq", 16'h0001, 16'(host_irq & sys_err));
    rd(8'h02);
    chk("process flag", 16'h0010, rd_v);
    wr(8'h02, 16'h003F);
    ev(8'h01);
    rd(8'h02);
    chk("bus flag", 16'h0008, rd_v);
    wr(8'h02, 16'h003F);
  endtask
  task automatic t_run();
    int n = 0;
    cmd_run = 1;
    cyc();
    chk("sof start", 16'h0001, 16'(exec_en & sof_start));
    chk("index wr locked", 16'h0000, 16'(frame_index_wr_ok));
    while (!frame_tick && n < 40) begin
      cyc();
      n++;
    end
    n = 0;
    do begin
      cyc();
      n++;
    end while (!frame_tick && n < 40);
    chk("frame gap", 16'd16, 16'(n));
    cmd_run = 0;
    cyc(2);
    rd(8'h02);
    chk("halted", 16'h0020, rd_v);
    wr(8'h02, 16'h0020);
  endtask
  task automatic t_step();
    single_step_debug_bit = 1;
    cmd_run = 1;
    cyc(2);
    td_fetch = 1;
    eng_busy = 1;
    cyc();
    td_fetch = 0;
    chk("run clear", 16'h0001, 16'(run_clr));
    cmd_run = 0;
    cyc(3);
    rd(8'h02);
    chk("busy not halted", 16'h0000, rd_v);
    eng_busy = 0;
    cyc(2);
    rd(8'h02);
    chk("step halted", 16'h0020, rd_v);
    single_step_debug_bit = 0;
  endtask
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    {io_wr, io_rd, cmd_run, single_step_debug_bit, global_suspend_bit,
      eng_busy, td_fetch, io_addr, io_wdata} = '0;
    {td_done, td_ioc, td_err, td_short, td_spd, resume_det, check_fail,
      bus_abort} = 8'h00;
    io_be = 2'h3;
    rst = 1;
    cyc(10);
    rst = 0;
    t_regs();
    t_flags();
    t_fatal();
    t_run();
    t_step();
    stop_test();
  end
endmodule
`default_nettype wire
